// ### core/video_in_raw_message_capture.sv
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R01: one sample per link clock with valid
// R02: pack four bytes or two halfwords per word
// R03: widen tenbit samples by sign or zero
// R04: ascending addresses, endian bit orders halfwords
// R05: any reset clears all control and status; soft reset keeps buffer starts, size and current address
// R06: software sizes buffers in multiples of 64
// R07: enable starts buffer one, pointer advances
// R08: full buffer switches seamlessly, sets full flag
// R09: both buffers full raises overrun, stops
// R10: either release resumes capture despite overrun
// R11: overrun clears only by its clear bit
// R12: staging overflow drops samples, sticky bandwidth flag
// R13: base and size copied at buffer use
// R14: buffer starts forced 64-byte aligned
// R15: message bytes from low lines, packed four
// R16: start on line 8, bytes follow next edge
// R17: end marker on line 9 with last byte
// R18: message end switches buffer, overrun likewise
// R19: buffer full mid-message sets overflow, halts
// R20: message size changed only with soft reset
// R21: two staging banks of sixteen words
// R22: arbiter serves one write per bank time
// R23: interrupt held while enabled flag set
// R24: resume in released buffer, one on tie
module video_in_raw_message_capture
  import video_in_capture_pkg::*;
#(
  parameter int DATA_LINES = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic senderLinkClock,
  input wire logic sampleValidStrobe,
  input wire logic [DATA_LINES-1:0] inputSampleLines,
  output logic memReq,
  output logic [31:0] memAddr,
  output logic [31:0] memData,
  input wire logic memAck,
  output logic irqReq
);

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  logic ack_q;
  logic [31:0] rdData_q;
  logic access;
  logic wrCtl;
  logic swRst_q;
  logic captureEnable_q;
  capture_mode_t mode_q;
  logic littleEndian_q;
  logic [FLAG_COUNT-1:0] intEnable_q;
  logic [31:0] firstBufferStart_q;
  logic [31:0] secondBufferStart_q;
  logic [SIZE_WIDTH-1:0] size_q;
  logic [FLAG_COUNT-1:0] clearBits;
  logic [FLAG_COUNT-1:0] flags;
  logic [31:0] curAdr_q;
  logic active_q;
  logic stopped_q;
  message_state_t msgState_q;

  assign access = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wrCtl = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & (wb_adr_i == CTL_OFFSET);
  // release and clear bits are write-only pulses in byte lane two
  assign clearBits = (wrCtl & wb_sel_i[2]) ? wb_dat_i[CTL_ACK_LSB +: FLAG_COUNT] : '0;

  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeLanes

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      rdData_q <= REG_RESET;
    end
    else if (clkEn)
    begin
      // one wait state; unmapped reads answer zero, unmapped writes vanish
      ack_q <= access;
      if (access && !wb_we_i)
      begin
        if (wb_adr_i == CTL_OFFSET)
        begin
          rdData_q <= {19'h00000, intEnable_q, 4'h0, littleEndian_q, mode_q,
                       captureEnable_q};
        end
        else if (wb_adr_i == STATUS_OFFSET)
        begin
          rdData_q <= {24'h00_0000, (msgState_q == MSG_RECEIVE), stopped_q, active_q, flags};
        end
        else if (wb_adr_i == FIRST_START_OFFSET)
        begin
          rdData_q <= firstBufferStart_q;
        end
        else if (wb_adr_i == SECOND_START_OFFSET)
        begin
          rdData_q <= secondBufferStart_q;
        end
        else if (wb_adr_i == SIZE_OFFSET)
        begin
          rdData_q <= {8'h00, size_q};
        end
        else if (wb_adr_i == CUR_ADR_OFFSET)
        begin
          rdData_q <= curAdr_q;
        end
        else
        begin
          rdData_q <= REG_RESET;
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdData_q;

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      swRst_q <= 1'b0;
      captureEnable_q <= 1'b0;
      mode_q <= BYTE_SAMPLE_MODE;
      littleEndian_q <= 1'b0;
      intEnable_q <= '0;
      firstBufferStart_q <= REG_RESET;
      secondBufferStart_q <= REG_RESET;
      size_q <= '0;
    end
    else if (clkEn)
    begin
      swRst_q <= wrCtl & wb_sel_i[0] & wb_dat_i[CTL_SOFT_RESET_BIT];
      if (swRst_q)
      begin
        captureEnable_q <= 1'b0; // see R05
        mode_q <= BYTE_SAMPLE_MODE;
        littleEndian_q <= 1'b0;
        intEnable_q <= '0;
      end
      else if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i)
      begin
        if (wb_adr_i == CTL_OFFSET)
        begin
          if (wb_sel_i[0])
          begin
            captureEnable_q <= wb_dat_i[CTL_ENABLE_BIT];
            mode_q <= capture_mode_t'(wb_dat_i[CTL_MODE_LSB +: 2]);
            littleEndian_q <= wb_dat_i[CTL_LITTLE_BIT];
          end
          if (wb_sel_i[1])
          begin
            intEnable_q <= wb_dat_i[CTL_IE_LSB +: FLAG_COUNT];
          end
        end
        else if (wb_adr_i == FIRST_START_OFFSET)
        begin
          firstBufferStart_q <= mergeLanes(firstBufferStart_q, wb_dat_i, wb_sel_i)
                                & ~32'h0000_003F; // see R14
        end
        else if (wb_adr_i == SECOND_START_OFFSET)
        begin
          secondBufferStart_q <= mergeLanes(secondBufferStart_q, wb_dat_i, wb_sel_i)
                                 & ~32'h0000_003F; // see R14
        end
        else if (wb_adr_i == SIZE_OFFSET)
        begin
          size_q <= SIZE_WIDTH'(mergeLanes({8'h00, size_q}, wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  // ****************************************************************
  // link input synchroniser, all lines share the same three stages
  // ****************************************************************
  logic [DATA_LINES+1:0] linkSync_q [LINK_SYNC_STAGES];
  logic linkLevel_q;
  logic linkAgree;
  logic linkEdge;
  logic [DATA_LINES-1:0] lines;
  logic validIn;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int s = 0; s < LINK_SYNC_STAGES; s++)
      begin
        linkSync_q[s] <= '0;
      end
      linkLevel_q <= 1'b0;
    end
    else if (clkEn)
    begin
      linkSync_q[0] <= {senderLinkClock, sampleValidStrobe, inputSampleLines};
      for (int s = 1; s < LINK_SYNC_STAGES; s++)
      begin
        linkSync_q[s] <= linkSync_q[s-1];
      end
      if (linkAgree)
      begin
        linkLevel_q <= linkSync_q[1][DATA_LINES+1];
      end
    end
  end

  assign linkAgree = linkSync_q[1][DATA_LINES+1] == linkSync_q[2][DATA_LINES+1];
  assign linkEdge = linkAgree & linkSync_q[1][DATA_LINES+1] & ~linkLevel_q;
  assign lines = linkSync_q[2][DATA_LINES-1:0];
  assign validIn = linkSync_q[2][DATA_LINES];

  // ****************************************************************
  // sample packing and buffer sequencing
  // ****************************************************************
  logic is16;
  logic isMsg;
  logic [15:0] wide;
  logic take;
  logic [1:0] lane_q;
  logic [31:0] word_q;
  logic [31:0] wordD;
  logic lastLane;
  logic [SIZE_WIDTH-1:0] remain_q;
  logic endBuf;
  logic endMsg;
  logic bufDone;
  logic push;
  logic enablePrev_q;
  logic [1:0] full_q;
  logic overrun_q;
  logic overflow_q;
  logic bandwidth_q;
  logic [1:0] relBits;
  logic [1:0] laneSlot;

  assign is16 = (mode_q == SIGNED_TENBIT_MODE) || (mode_q == UNSIGNED_TENBIT_MODE);
  assign isMsg = mode_q == MESSAGE_MODE;
  assign relBits = clearBits[FLAG_FULL2:FLAG_FULL1];
  // see R03
  assign wide = (mode_q == SIGNED_TENBIT_MODE) ? {{6{lines[9]}}, lines[9:0]}
                                               : {6'h00, lines[9:0]};
  // sample values never start or stop capture in raw modes
  assign take = linkEdge & captureEnable_q & enablePrev_q & ~stopped_q
                & (isMsg ? (msgState_q == MSG_RECEIVE) : validIn); // see R01 R16
  assign lastLane = is16 ? lane_q[0] : (lane_q == 2'd3);
  assign endBuf = remain_q == SIZE_WIDTH'(1);
  assign endMsg = isMsg & lines[9]; // see R17
  assign bufDone = take & (endBuf | endMsg);
  assign push = take & (lastLane | endBuf | endMsg);

  always_comb
  begin
    wordD = word_q;
    laneSlot = littleEndian_q ? lane_q : ~lane_q;
    // big endian puts the earliest sample in the high lanes
    if (is16)
    begin
      wordD[laneSlot[0] * 16 +: 16] = wide; // see R02 R04
    end
    else
    begin
      wordD[laneSlot * 8 +: 8] = lines[7:0]; // see R02 R15
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enablePrev_q <= 1'b0;
      active_q <= 1'b0;
      stopped_q <= 1'b0;
      lane_q <= 2'd0;
      word_q <= REG_RESET;
      curAdr_q <= REG_RESET;
      remain_q <= '0;
      msgState_q <= MSG_WAIT_START;
    end
    else if (clkEn)
    begin
      enablePrev_q <= captureEnable_q & ~swRst_q;
      if (swRst_q || !captureEnable_q)
      begin
        stopped_q <= 1'b0; // see R05
        active_q <= 1'b0;
        lane_q <= 2'd0;
        word_q <= REG_RESET;
        msgState_q <= MSG_WAIT_START;
      end
      else if (!enablePrev_q)
      begin
        active_q <= 1'b0; // see R07 R13
        curAdr_q <= firstBufferStart_q;
        remain_q <= size_q;
      end
      else if (stopped_q && (relBits != 2'b00))
      begin
        stopped_q <= 1'b0; // see R10 R24
        active_q <= ~relBits[0];
        curAdr_q <= relBits[0] ? firstBufferStart_q : secondBufferStart_q;
        remain_q <= size_q;
        lane_q <= 2'd0;
        word_q <= REG_RESET;
      end
      else
      begin
        if (isMsg && linkEdge && (msgState_q == MSG_WAIT_START) && lines[8] && !stopped_q)
        begin
          msgState_q <= MSG_RECEIVE; // see R16
        end
        if (take)
        begin
          curAdr_q <= curAdr_q + (is16 ? 32'h0000_0002 : 32'h0000_0001); // see R07
          remain_q <= remain_q - SIZE_WIDTH'(1);
          lane_q <= push ? 2'd0 : lane_q + 2'd1;
          word_q <= push ? REG_RESET : wordD;
        end
        if (bufDone)
        begin
          msgState_q <= MSG_WAIT_START; // see R17 R19
          if (full_q[~active_q] && !relBits[~active_q])
          begin
            stopped_q <= 1'b1; // see R09 R18
          end
          else
          begin
            active_q <= ~active_q; // see R08 R13
            curAdr_q <= active_q ? firstBufferStart_q : secondBufferStart_q;
            remain_q <= size_q;
          end
        end
      end
    end
  end

  // ****************************************************************
  // sticky event flags, a set in the same cycle beats its clear
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      full_q <= 2'b00;
      overrun_q <= 1'b0;
      overflow_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (swRst_q)
      begin
        full_q <= 2'b00;
        overrun_q <= 1'b0;
        overflow_q <= 1'b0;
      end
      else
      begin
        for (int b = 0; b < 2; b++)
        begin
          if (bufDone && (active_q == b[0]))
          begin
            full_q[b] <= 1'b1; // see R08 R18
          end
          else if (relBits[b])
          begin
            full_q[b] <= 1'b0;
          end
        end
        if (bufDone && full_q[~active_q] && !relBits[~active_q])
        begin
          overrun_q <= 1'b1; // see R09
        end
        else if (clearBits[FLAG_OVERRUN])
        begin
          overrun_q <= 1'b0; // see R11
        end
        if (take && isMsg && endBuf && !endMsg)
        begin
          overflow_q <= 1'b1; // see R19
        end
        else if (clearBits[FLAG_OVERFLOW])
        begin
          overflow_q <= 1'b0; // see R19
        end
      end
    end
  end

  assign flags = {overflow_q, bandwidth_q, overrun_q, full_q};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqReq <= 1'b0;
    end
    else if (clkEn)
    begin
      irqReq <= |(flags & intEnable_q); // see R23
    end
  end

  // ****************************************************************
  // staging banks toward the highway
  // ****************************************************************
  // each entry keeps its own word address, so dropped words leave a gap
  // and the following words still land where they belong
  logic [31:0] stageData_q [STAGE_BANKS][STAGE_DEPTH];
  logic [29:0] stageAdr_q [STAGE_BANKS][STAGE_DEPTH];
  logic [4:0] bankCount_q [STAGE_BANKS];
  logic [STAGE_BANKS-1:0] bankReady_q;
  logic fillBank_q;
  logic drainBank_q;
  logic [3:0] drainIdx_q;
  logic flushNow;
  logic memReq_q;
  logic [31:0] memAddr_q;
  logic [31:0] memData_q;

  // a finished buffer or message goes out without waiting for sixteen words
  assign flushNow = bufDone;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int b = 0; b < STAGE_BANKS; b++)
      begin
        bankCount_q[b] <= 5'd0;
        for (int e = 0; e < STAGE_DEPTH; e++)
        begin
          stageData_q[b][e] <= REG_RESET;
          stageAdr_q[b][e] <= 30'h0000_0000;
        end
      end
      bankReady_q <= '0;
      fillBank_q <= 1'b0;
      drainBank_q <= 1'b0;
      drainIdx_q <= 4'd0;
      bandwidth_q <= 1'b0;
      memReq_q <= 1'b0;
      memAddr_q <= REG_RESET;
      memData_q <= REG_RESET;
    end
    else if (clkEn)
    begin
      if (swRst_q)
      begin
        for (int b = 0; b < STAGE_BANKS; b++)
        begin
          bankCount_q[b] <= 5'd0;
        end
        bankReady_q <= '0;
        fillBank_q <= 1'b0;
        drainBank_q <= 1'b0;
        drainIdx_q <= 4'd0;
        bandwidth_q <= 1'b0;
        memReq_q <= 1'b0;
      end
      else
      begin
        if (push && bankReady_q[fillBank_q])
        begin
          bandwidth_q <= 1'b1; // see R12
        end
        else if (clearBits[FLAG_BANDWIDTH])
        begin
          bandwidth_q <= 1'b0; // see R12
        end
        if (push && !bankReady_q[fillBank_q])
        begin
          stageData_q[fillBank_q][bankCount_q[fillBank_q][3:0]] <= wordD; // see R21
          stageAdr_q[fillBank_q][bankCount_q[fillBank_q][3:0]] <= curAdr_q[31:2];
          bankCount_q[fillBank_q] <= bankCount_q[fillBank_q] + 5'd1;
          if ((bankCount_q[fillBank_q] == 5'(STAGE_DEPTH - 1)) || flushNow)
          begin
            bankReady_q[fillBank_q] <= 1'b1;
            fillBank_q <= ~fillBank_q;
          end
        end
        if (!memReq_q && bankReady_q[drainBank_q])
        begin
          memReq_q <= 1'b1;
          memAddr_q <= {stageAdr_q[drainBank_q][drainIdx_q], 2'b00};
          memData_q <= stageData_q[drainBank_q][drainIdx_q];
        end
        else if (memReq_q && memAck)
        begin
          memReq_q <= 1'b0;
          if (5'(drainIdx_q) + 5'd1 == bankCount_q[drainBank_q])
          begin
            // fill side never touches a ready bank, so no write conflict here
            bankReady_q[drainBank_q] <= 1'b0;
            bankCount_q[drainBank_q] <= 5'd0;
            drainBank_q <= ~drainBank_q;
            drainIdx_q <= 4'd0;
          end
          else
          begin
            drainIdx_q <= drainIdx_q + 4'd1;
          end
        end
      end
    end
  end

  assign memReq = memReq_q;
  assign memAddr = memAddr_q;
  assign memData = memData_q;

endmodule : video_in_raw_message_capture

// ### core/video_in_capture_pkg.sv
package video_in_capture_pkg;

  // ****************************************************************
  // register map, byte addresses on the wishbone slave
  // ****************************************************************
  localparam logic [7:0] CTL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FIRST_START_OFFSET = 8'h08;
  localparam logic [7:0] SECOND_START_OFFSET = 8'h0C;
  localparam logic [7:0] SIZE_OFFSET = 8'h10;
  localparam logic [7:0] CUR_ADR_OFFSET = 8'h14;

  // ****************************************************************
  // capture control register fields
  // ****************************************************************
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_MODE_LSB = 1;
  localparam int CTL_LITTLE_BIT = 3;
  localparam int CTL_SOFT_RESET_BIT = 4;
  localparam int CTL_IE_LSB = 8;
  localparam int CTL_ACK_LSB = 16;

  // ****************************************************************
  // event flag positions, shared by status, enables and acknowledges
  // ****************************************************************
  localparam int FLAG_FULL1 = 0;
  localparam int FLAG_FULL2 = 1;
  localparam int FLAG_OVERRUN = 2;
  localparam int FLAG_BANDWIDTH = 3;
  localparam int FLAG_OVERFLOW = 4;
  localparam int FLAG_COUNT = 5;
  localparam int STATUS_ACTIVE_BIT = 5;
  localparam int STATUS_STOPPED_BIT = 6;
  localparam int STATUS_RECEIVING_BIT = 7;

  // ****************************************************************
  // layout figures and reset values
  // ****************************************************************
  localparam int BASE_ALIGN_BITS = 6;
  localparam int SIZE_WIDTH = 24;
  localparam int STAGE_DEPTH = 16;
  localparam int STAGE_BANKS = 2;
  localparam int LINK_SYNC_STAGES = 3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    BYTE_SAMPLE_MODE,
    SIGNED_TENBIT_MODE,
    UNSIGNED_TENBIT_MODE,
    MESSAGE_MODE
  } capture_mode_t;

  typedef enum logic {
    MSG_WAIT_START,
    MSG_RECEIVE
  } message_state_t;

endpackage : video_in_capture_pkg

// ### verif/video_in_raw_message_capture_asserts.sv
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module video_in_raw_message_capture_asserts #(
  parameter int DATA_LINES = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memData,
  input wire logic memAck,
  input wire logic irqReq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_RESET_QUIET: assert property ($rose(reset_n) |-> !memReq && !irqReq)
    else $error("output active after reset");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  AST_ACK_PULSE: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_IRQ_DROP: assert property ($fell(irqReq) |-> $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("interrupt dropped without a register write");
  AST_MEM_HOLD: assert property (memReq && !memAck |=>
    memReq && $stable(memAddr) && $stable(memData))
    else $error("highway request changed before accept");
  AST_MEM_GAP: assert property (memReq && memAck && clkEn |=> !memReq)
    else $error("highway request not dropped after accept");
  AST_WORD_ALIGN: assert property (memReq |-> memAddr[1:0] == 2'b00)
    else $error("highway address not word aligned");
  AST_FREEZE: assert property (!clkEn |=>
    $stable(memReq) && $stable(irqReq) && $stable(wb_ack_o))
    else $error("outputs moved while clock enable low");

  cover property ($rose(irqReq));
  cover property ($fell(irqReq));
  cover property (memReq && memAck);
endmodule : video_in_raw_message_capture_asserts

bind video_in_raw_message_capture video_in_raw_message_capture_asserts #(
  .DATA_LINES(DATA_LINES)
) i_video_in_raw_message_capture_asserts (
  .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .memReq(memReq), .memAddr(memAddr), .memData(memData),
  .memAck(memAck), .irqReq(irqReq)
);

// ### verif/link_sender_model.sv
`timescale 1ns/1ps
// ****************
// sender and highway model
// ****************
module link_sender_model (
  input wire logic clk,
  input wire logic [11:0] ackDelay,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memData,
  output logic memAck,
  output logic senderLinkClock,
  output logic sampleValidStrobe,
  output logic [9:0] inputSampleLines
);
  logic [31:0] mem [logic [31:0]];
  logic [11:0] waitCnt = 12'h000;

  initial
  begin
    memAck = 1'b0;
    senderLinkClock = 1'b0;
    sampleValidStrobe = 1'b0;
    inputSampleLines = 10'h000;
  end

  // one link period of 8 clocks; clock stands still between calls and
  // released lines invert so a stale value can never look valid
  task automatic linkCycle(input logic [9:0] d, input logic v);
    @(posedge clk);
    inputSampleLines <= d;
    sampleValidStrobe <= v;
    repeat (3) @(posedge clk);
    senderLinkClock <= 1'b1;
    repeat (4) @(posedge clk);
    senderLinkClock <= 1'b0;
    inputSampleLines <= ~d;
    sampleValidStrobe <= 1'b0;
  endtask : linkCycle

  always @(posedge clk)
  begin
    memAck <= 1'b0;
    if (memReq && !memAck)
    begin
      if (waitCnt >= ackDelay)
      begin
        memAck <= 1'b1;
        mem[memAddr] = memData;
        waitCnt <= 12'h000;
      end
      else
        waitCnt <= waitCnt + 12'h001;
    end
  end
endmodule : link_sender_model

// ### verif/video_in_raw_message_capture_tb_top.sv
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module video_in_raw_message_capture_tb_top import video_in_capture_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic senderLinkClock;
  logic sampleValidStrobe;
  logic [9:0] inputSampleLines;
  logic memReq;
  logic [31:0] memAddr;
  logic [31:0] memData;
  logic memAck;
  logic irqReq;
  logic [11:0] ackDelay = 12'h000;
  logic [31:0] rdat;
  int num_errors = 0;
  int checks_done = 0;

  always #25 clk = ~clk;

  video_in_raw_message_capture i_video_in_raw_message_capture (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .senderLinkClock(senderLinkClock),
    .sampleValidStrobe(sampleValidStrobe), .inputSampleLines(inputSampleLines),
    .memReq(memReq), .memAddr(memAddr), .memData(memData), .memAck(memAck), .irqReq(irqReq)
  );

  link_sender_model i_link_sender_model (
    .clk(clk), .ackDelay(ackDelay), .memReq(memReq), .memAddr(memAddr), .memData(memData),
    .memAck(memAck), .senderLinkClock(senderLinkClock),
    .sampleValidStrobe(sampleValidStrobe), .inputSampleLines(inputSampleLines)
  );

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // entered just after an edge; request held until ack is sampled
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    if (wb_ack_o !== 1'b1)
      cmp(32'h0000_0000, 32'h0000_0001);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wbXfer

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
    wbXfer(1'b0, adr, 32'h0000_0000);
    cmp(rdat & m, e);
  endtask : rdChk

  task automatic memChk(input logic [31:0] a, input logic [31:0] e);
    int n;
    n = 0;
    while (!i_link_sender_model.mem.exists(a) && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    cmp(i_link_sender_model.mem[a], e);
  endtask : memChk

  task automatic sendRaw(input int cnt, input logic [9:0] first);
    for (int i = 0; i < cnt; i++)
    begin
      if (i % 4 == 2)
        i_link_sender_model.linkCycle(10'h155, 1'b0);
      i_link_sender_model.linkCycle(first + 10'(i), 1'b1);
    end
  endtask : sendRaw

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdChk(CTL_OFFSET, 32'hFFFF_FFFF, REG_RESET);
    rdChk(STATUS_OFFSET, 32'hFFFF_FFFF, REG_RESET);
    rdChk(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    clkEn <= 1'b1;
    @(posedge clk);
    wbXfer(1'b1, FIRST_START_OFFSET, 32'h0000_1005);
    rdChk(FIRST_START_OFFSET, 32'hFFFF_FFFF, 32'h0000_1000);
    wbXfer(1'b1, SECOND_START_OFFSET, 32'h0000_2000);
    wbXfer(1'b1, SIZE_OFFSET, 32'h0000_0040);
    $display("test reset done");
    wbXfer(1'b1, CTL_OFFSET, 32'h0000_0101);
    sendRaw(64, 10'h000);
    for (int k = 0; k < 16; k++)
      memChk(32'h1000 + 32'(4 * k), {8'(4 * k), 8'(4 * k + 1), 8'(4 * k + 2), 8'(4 * k + 3)});
    rdChk(STATUS_OFFSET, 32'h0000_0021, 32'h0000_0021);
    rdChk(CUR_ADR_OFFSET, 32'hFFFF_FFFF, 32'h0000_2000);
    cmp({31'h0, irqReq}, 32'h0000_0001);
    $display("test byte capture done");
    wbXfer(1'b1, FIRST_START_OFFSET, 32'h0000_3000);
    sendRaw(64, 10'h040);
    memChk(32'h0000_2000, 32'h4041_4243);
    rdChk(STATUS_OFFSET, 32'h0000_0047, 32'h0000_0047);
    sendRaw(4, 10'h0EE);
    wbXfer(1'b1, CTL_OFFSET, 32'h0001_0101);
    rdChk(STATUS_OFFSET, 32'h0000_0067, 32'h0000_0006);
    cmp({31'h0, irqReq}, 32'h0000_0000);
    wbXfer(1'b1, CTL_OFFSET, 32'h0004_0101);
    rdChk(STATUS_OFFSET, 32'h0000_0004, 32'h0000_0000);
    sendRaw(64, 10'h080);
    memChk(32'h0000_3000, 32'h8081_8283);
    memChk(32'h0000_303C, 32'hBCBD_BEBF);
    $display("test overrun done");
    // soft reset only with the highway idle
    for (int m = 1; m <= 2; m++)
    begin
      wbXfer(1'b1, CTL_OFFSET, 32'h0000_0010);
      repeat (2) @(posedge clk);
      rdChk(STATUS_OFFSET, 32'hFFFF_FFFF, REG_RESET);
      i_link_sender_model.mem.delete();
      ackDelay <= 12'd20;
      wbXfer(1'b1, CTL_OFFSET, 32'h0000_0009 | 32'(m << 1));
      sendRaw(32, 10'h200);
      memChk(32'h0000_3000, (m == 1) ? 32'hFE01_FE00 : 32'h0201_0200);
      memChk(32'h0000_303C, (m == 1) ? 32'hFE1F_FE1E : 32'h021F_021E);
      rdChk(CUR_ADR_OFFSET, 32'hFFFF_FFFF, 32'h0000_3040);
    end
    $display("test tenbit done");
    wbXfer(1'b1, CTL_OFFSET, 32'h0000_0010);
    repeat (2) @(posedge clk);
    i_link_sender_model.mem.delete();
    ackDelay <= 12'd0;
    wbXfer(1'b1, CTL_OFFSET, 32'h0000_1007);
    i_link_sender_model.linkCycle(10'h100, 1'b1);
    for (int b = 0; b < 8; b++)
      i_link_sender_model.linkCycle({b == 7, 1'b0, 8'hA0 + 8'(b)}, 1'b1);
    memChk(32'h0000_3000, 32'hA0A1_A2A3);
    memChk(32'h0000_3004, 32'hA4A5_A6A7);
    rdChk(STATUS_OFFSET, 32'h0000_0021, 32'h0000_0021);
    i_link_sender_model.linkCycle(10'h100, 1'b1);
    for (int b = 0; b < 66; b++)
      i_link_sender_model.linkCycle(10'(b), 1'b1);
    memChk(32'h0000_203C, 32'h3C3D_3E3F);
    rdChk(STATUS_OFFSET, 32'h0000_0010, 32'h0000_0010);
    cmp({31'h0, irqReq}, 32'h0000_0001);
    wbXfer(1'b1, CTL_OFFSET, 32'h0010_1007);
    rdChk(STATUS_OFFSET, 32'h0000_0010, 32'h0000_0000);
    cmp({31'h0, irqReq}, 32'h0000_0000);
    $display("test message done");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule : video_in_raw_message_capture_tb_top
